// file: hw/t0at_pkg.sv
// shared constants and helpers for the t0 apdu transport ends
package t0at_pkg;
  localparam logic [7:0] T0AT_CLA_GR = 8'h00;
  localparam logic [7:0] T0AT_INS_GR = 8'hc0;
  localparam logic [7:0] T0AT_P12_GR = 8'h00;
  localparam logic [7:0] T0AT_LE_ZERO = 8'h00;
  localparam logic [7:0] T0AT_NULL = 8'h60;
  localparam logic [7:0] T0AT_SW1_MORE = 8'h61;
  localparam logic [7:0] T0AT_SW1_FIX = 8'h6c;
  localparam logic [7:0] T0AT_SW1_WARN_A = 8'h62;
  localparam logic [7:0] T0AT_SW1_WARN_B = 8'h63;
  localparam logic [3:0] T0AT_NIB_SW_A = 4'h6;
  localparam logic [3:0] T0AT_NIB_SW_B = 4'h9;
  localparam logic [15:0] T0AT_SW_OK = 16'h9000;
  localparam logic [15:0] T0AT_SW_CORRUPT = 16'h6281;
  localparam logic [15:0] T0AT_SW_BADLEN = 16'h6700;
  localparam logic [15:0] T0AT_SW_BADP12 = 16'h6a86;
  localparam logic [15:0] T0AT_SW_NODIAG = 16'h6f00;
  localparam logic [2:0] T0AT_CASE2 = 3'h2;
  localparam logic [2:0] T0AT_CASE3 = 3'h3;
  localparam logic [2:0] T0AT_CASE4 = 3'h4;
  localparam logic [2:0] T0AT_HDR_LAST = 3'h4;
  localparam logic [8:0] T0AT_LEN_FULL = 9'h100;

  // a length byte of zero stands for 256
  function automatic logic [8:0] t0at_len9(input logic [7:0] b);
    t0at_len9 = (b == T0AT_LE_ZERO) ? T0AT_LEN_FULL : {1'b0, b};
  endfunction
endpackage

// file: hw/t0at_link_if.sv
// byte link between the terminal transport end and the card end
`timescale 1ns/100ps
interface t0at_link_if;
  logic [7:0] t2c_data;
  logic t2c_valid;
  logic t2c_ready;
  logic [7:0] c2t_data;
  logic c2t_valid;
  logic c2t_ready;
  modport term (output t2c_data, output t2c_valid, input t2c_ready,
                input c2t_data, input c2t_valid, output c2t_ready);
  modport card (input t2c_data, input t2c_valid, output t2c_ready,
                output c2t_data, output c2t_valid, input c2t_ready);
endinterface

// file: hw/t0at_card.sv
// card end: answers t0 headers with procedure bytes, data and status
`timescale 1ns/100ps
module t0at_card import t0at_pkg::*; (
  input wire logic clk, // 20 mhz clock
  input wire logic reset, // async, active high
  output logic hdr_strobe, // pulse: header complete
  output logic [7:0] hdr_ins, // received instruction
  output logic [7:0] hdr_p3, // received length byte
  output logic [7:0] cdata, // command data byte
  output logic cdata_valid, // pulse per command data byte
  input wire logic app_resp, // pulse: application decision
  input wire logic [2:0] app_case, // case of the command
  input wire logic app_ok, // normal processing
  input wire logic [15:0] app_sw, // status when not ok
  input wire logic [8:0] app_len, // available response length
  input wire logic [7:0] rd_data, // response data byte
  input wire logic rd_valid, // response byte offered
  input wire logic rd_bad, // byte may be corrupted
  output logic rd_ack, // pulse: response byte taken
  t0at_link_if.card link // link to terminal
);
  typedef enum {C_HDR, C_WAIT, C_ACK, C_RXD, C_TXD, C_PAIR} t0at_cstate_t;
  t0at_cstate_t st_reg, nxt_reg;
  logic [7:0] hdr_reg [0:4];
  logic [2:0] idx_reg;
  logic [8:0] cnt_reg, rem_reg;
  logic [15:0] pair_reg;
  logic pidx_reg, got_reg, bad_reg, rdy_reg, cv_reg;
  logic [7:0] cd_reg;
  logic rx, txd, is_gr, go;
  logic [8:0] le9, licc;

  assign link.t2c_ready = rdy_reg;
  assign link.c2t_valid = cv_reg;
  assign link.c2t_data = cd_reg;
  assign rx = link.t2c_valid & rdy_reg & (st_reg == C_HDR || st_reg == C_RXD);
  assign txd = cv_reg & link.c2t_ready;
  assign is_gr = hdr_reg[1] == T0AT_INS_GR;
  assign le9 = t0at_len9(hdr_reg[4]);
  assign licc = is_gr ? rem_reg : app_len;
  // get response needs no application decision
  assign go = (st_reg == C_WAIT) & (is_gr | app_resp);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= C_HDR;
      nxt_reg <= C_HDR;
      idx_reg <= 3'h0;
      cnt_reg <= 9'h000;
      rem_reg <= 9'h000;
      pair_reg <= 16'h0000;
      pidx_reg <= 1'b0;
      got_reg <= 1'b0;
      bad_reg <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        hdr_reg[i] <= 8'h00;
      end
    end else begin
      case (st_reg)
        C_HDR: if (rx) begin
          hdr_reg[idx_reg] <= link.t2c_data;
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == T0AT_HDR_LAST) begin
            st_reg <= C_WAIT;
            got_reg <= 1'b0;
            if (hdr_reg[1] != T0AT_INS_GR) begin
              rem_reg <= 9'h000;
            end
          end
        end
        C_WAIT: if (go) begin
          st_reg <= C_PAIR;
          pidx_reg <= 1'b0;
          if (is_gr && (hdr_reg[2] != T0AT_P12_GR || hdr_reg[3] != T0AT_P12_GR)) begin
            pair_reg <= T0AT_SW_BADP12;
          end else if (is_gr && rem_reg == 9'h000) begin
            pair_reg <= T0AT_SW_NODIAG;
          end else if (!is_gr && !app_ok) begin
            pair_reg <= app_sw;
          end else if (!is_gr && app_case != T0AT_CASE2 && !got_reg) begin
            st_reg <= C_ACK;
            nxt_reg <= C_RXD;
            cnt_reg <= {1'b0, hdr_reg[4]};
          end else if (!is_gr && app_case == T0AT_CASE3) begin
            pair_reg <= T0AT_SW_OK;
          end else if (!is_gr && app_case == T0AT_CASE4) begin
            rem_reg <= app_len;
            pair_reg <= {T0AT_SW1_MORE, app_len[7:0]};
          end else if (hdr_reg[4] == T0AT_LE_ZERO && licc != T0AT_LEN_FULL || le9 > licc) begin
            // a get response asking more than is left is refused, unless its length byte is 00, which is corrected
            if (is_gr && hdr_reg[4] != T0AT_LE_ZERO) begin
              pair_reg <= T0AT_SW_BADLEN;
            end else begin
              pair_reg <= {T0AT_SW1_FIX, licc[7:0]};
            end
          end else begin
            st_reg <= C_ACK;
            nxt_reg <= C_TXD;
            cnt_reg <= le9;
            rem_reg <= licc - le9;
            bad_reg <= 1'b0;
          end
        end
        C_ACK: if (txd) begin
          st_reg <= nxt_reg;
        end
        C_RXD: if (rx) begin
          cnt_reg <= cnt_reg - 9'h001;
          if (cnt_reg == 9'h001) begin
            got_reg <= 1'b1;
            st_reg <= C_WAIT;
          end
        end
        C_TXD: begin
          if (rd_ack) begin
            bad_reg <= bad_reg | rd_bad;
          end
          if (txd) begin
            cnt_reg <= cnt_reg - 9'h001;
            if (cnt_reg == 9'h001) begin
              st_reg <= C_PAIR;
              pidx_reg <= 1'b0;
              if (rem_reg != 9'h000) begin
                pair_reg <= {T0AT_SW1_MORE, rem_reg[7:0]};
              end else begin
                pair_reg <= bad_reg ? T0AT_SW_CORRUPT : T0AT_SW_OK;
              end
            end
          end
        end
        C_PAIR: if (txd) begin
          pidx_reg <= 1'b1;
          if (pidx_reg) begin
            st_reg <= C_HDR;
            idx_reg <= 3'h0;
          end
        end
        default: st_reg <= C_HDR;
      endcase
    end
  end

  // link output; one byte in flight, reloaded only once the last was taken
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cv_reg <= 1'b0;
      cd_reg <= 8'h00;
      rd_ack <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      rd_ack <= 1'b0;
      rdy_reg <= st_reg == C_HDR || st_reg == C_RXD;
      if (txd) begin
        cv_reg <= 1'b0;
      end else if (!cv_reg) begin
        if (st_reg == C_ACK) begin
          cv_reg <= 1'b1;
          cd_reg <= hdr_reg[1];
        end else if (st_reg == C_PAIR) begin
          cv_reg <= 1'b1;
          cd_reg <= pidx_reg ? pair_reg[7:0] : pair_reg[15:8];
        end else if (st_reg == C_TXD && rd_valid && !rd_ack) begin
          cv_reg <= 1'b1;
          cd_reg <= rd_data;
          rd_ack <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hdr_strobe <= 1'b0;
      hdr_ins <= 8'h00;
      hdr_p3 <= 8'h00;
      cdata <= 8'h00;
      cdata_valid <= 1'b0;
    end else begin
      hdr_strobe <= rx && st_reg == C_HDR && idx_reg == T0AT_HDR_LAST;
      if (rx && st_reg == C_HDR && idx_reg == T0AT_HDR_LAST) begin
        hdr_ins <= hdr_reg[1];
        hdr_p3 <= link.t2c_data;
      end
      cdata_valid <= rx && st_reg == C_RXD;
      if (rx && st_reg == C_RXD) begin
        cdata <= link.t2c_data;
      end
    end
  end
endmodule

// file: hw/t0at_term.sv
// terminal end: maps command apdus onto t0 headers and builds responses
`timescale 1ns/100ps
module t0at_term import t0at_pkg::*; (
  input wire logic clk, // 20 mhz clock
  input wire logic reset, // async, active high
  input wire logic cmd_start, // pulse: start a command
  input wire logic [2:0] cmd_case, // 2, 3 or 4
  input wire logic [7:0] cmd_cla, // class byte
  input wire logic [7:0] cmd_ins, // instruction byte
  input wire logic [7:0] cmd_p1, // parameter 1
  input wire logic [7:0] cmd_p2, // parameter 2
  input wire logic [7:0] cmd_lc, // command data length
  input wire logic [7:0] tx_data, // command data byte
  input wire logic tx_valid, // command data byte offered
  output logic tx_ack, // pulse: command byte taken
  output logic [7:0] rsp_data, // response body byte
  output logic rsp_valid, // pulse per body byte
  output logic rsp_done, // pulse: exchange finished
  output logic [15:0] rsp_sw, // trailer status
  output logic rsp_err, // pulse with done: abandoned
  output logic busy, // command in progress
  t0at_link_if.term link // link to card
);
  typedef enum {T_IDLE, T_HDR, T_PROC, T_SW2, T_DOUT, T_DIN} t0at_tstate_t;
  t0at_tstate_t st_reg;
  logic [7:0] hdr_reg [0:4];
  logic [2:0] idx_reg, case_reg;
  logic [7:0] lc_reg, sw1_reg, td_reg;
  logic [8:0] cnt_reg;
  logic [15:0] first_reg;
  logic sent_reg, gr_reg, have_reg, tv_reg, cr_reg;
  logic rx, txd, ack, nul, issw, perr, fix, more, cont4, fin;
  logic [7:0] b;
  logic [15:0] sw;

  assign link.t2c_valid = tv_reg;
  assign link.t2c_data = td_reg;
  assign link.c2t_ready = cr_reg;
  assign b = link.c2t_data;
  assign rx = link.c2t_valid & cr_reg;
  assign txd = tv_reg & link.t2c_ready;
  assign sw = {sw1_reg, b};

  always_comb begin
    ack = b == hdr_reg[1];
    nul = b == T0AT_NULL;
    issw = !nul && (b[7:4] == T0AT_NIB_SW_A || b[7:4] == T0AT_NIB_SW_B);
    perr = rx && st_reg == T_PROC && !ack && !nul && !issw;
    fix = sw1_reg == T0AT_SW1_FIX;
    more = sw1_reg == T0AT_SW1_MORE;
    cont4 = case_reg == T0AT_CASE4 && !gr_reg && sent_reg && (sw1_reg == T0AT_SW1_WARN_A
      || sw1_reg == T0AT_SW1_WARN_B || (sw1_reg[7:4] == T0AT_NIB_SW_B && sw != T0AT_SW_OK));
    fin = rx && st_reg == T_SW2 && !fix && !more && !cont4;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= T_IDLE;
      idx_reg <= 3'h0;
      case_reg <= T0AT_CASE2;
      lc_reg <= 8'h00;
      sw1_reg <= 8'h00;
      cnt_reg <= 9'h000;
      first_reg <= 16'h0000;
      sent_reg <= 1'b0;
      gr_reg <= 1'b0;
      have_reg <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        hdr_reg[i] <= 8'h00;
      end
    end else begin
      case (st_reg)
        T_IDLE: if (cmd_start) begin
          hdr_reg[0] <= cmd_cla;
          hdr_reg[1] <= cmd_ins;
          hdr_reg[2] <= cmd_p1;
          hdr_reg[3] <= cmd_p2;
          hdr_reg[4] <= (cmd_case == T0AT_CASE2) ? T0AT_LE_ZERO : cmd_lc;
          case_reg <= cmd_case;
          lc_reg <= cmd_lc;
          sent_reg <= 1'b0;
          gr_reg <= 1'b0;
          have_reg <= 1'b0;
          idx_reg <= 3'h0;
          st_reg <= T_HDR;
        end
        T_HDR: if (txd) begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == T0AT_HDR_LAST) begin
            st_reg <= T_PROC;
          end
        end
        T_PROC: if (rx) begin
          if (ack) begin
            if (case_reg != T0AT_CASE2 && !gr_reg && !sent_reg) begin
              st_reg <= T_DOUT;
              cnt_reg <= {1'b0, lc_reg};
            end else begin
              st_reg <= T_DIN;
              cnt_reg <= t0at_len9(hdr_reg[4]);
            end
          end else if (issw) begin
            sw1_reg <= b;
            st_reg <= T_SW2;
          end else if (!nul) begin
            st_reg <= T_IDLE;
          end
        end
        T_DOUT: if (txd) begin
          cnt_reg <= cnt_reg - 9'h001;
          if (cnt_reg == 9'h001) begin
            sent_reg <= 1'b1;
            st_reg <= T_PROC;
          end
        end
        T_DIN: if (rx) begin
          cnt_reg <= cnt_reg - 9'h001;
          if (cnt_reg == 9'h001) begin
            st_reg <= T_PROC;
          end
        end
        T_SW2: if (rx) begin
          idx_reg <= 3'h0;
          st_reg <= T_HDR;
          if (fix) begin
            hdr_reg[4] <= b;
          end else if (more || cont4) begin
            hdr_reg[0] <= T0AT_CLA_GR;
            hdr_reg[1] <= T0AT_INS_GR;
            hdr_reg[2] <= T0AT_P12_GR;
            hdr_reg[3] <= T0AT_P12_GR;
            hdr_reg[4] <= more ? b : T0AT_LE_ZERO;
            gr_reg <= 1'b1;
            if (cont4) begin
              first_reg <= sw;
              have_reg <= 1'b1;
            end
          end else begin
            st_reg <= T_IDLE;
          end
        end
        default: st_reg <= T_IDLE;
      endcase
    end
  end

  // one byte in flight; a command byte is taken only while none is pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tv_reg <= 1'b0;
      td_reg <= 8'h00;
      tx_ack <= 1'b0;
      cr_reg <= 1'b0;
    end else begin
      tx_ack <= 1'b0;
      cr_reg <= 1'b1;
      if (txd) begin
        tv_reg <= 1'b0;
      end else if (!tv_reg && st_reg == T_HDR) begin
        tv_reg <= 1'b1;
        td_reg <= hdr_reg[idx_reg];
      end else if (!tv_reg && st_reg == T_DOUT && tx_valid && !tx_ack) begin
        tv_reg <= 1'b1;
        td_reg <= tx_data;
        tx_ack <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_done <= 1'b0;
      rsp_sw <= 16'h0000;
      rsp_err <= 1'b0;
      busy <= 1'b0;
    end else begin
      rsp_valid <= rx && st_reg == T_DIN;
      if (rx && st_reg == T_DIN) begin
        rsp_data <= b;
      end
      rsp_done <= fin || perr;
      rsp_err <= perr;
      if (fin) begin
        rsp_sw <= have_reg ? first_reg : sw;
      end
      if (st_reg == T_IDLE && cmd_start) begin
        busy <= 1'b1;
      end else if (fin || perr) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: testbench/t0at_props.sv
// link protocol checker for the terminal/card byte link
`timescale 1ns/100ps
module t0at_props (
  input wire logic clk, // shared clock
  input wire logic reset, // async reset, active high
  input wire logic [7:0] t2c_data, // terminal to card byte
  input wire logic t2c_valid, // terminal byte offered
  input wire logic t2c_ready, // card ready
  input wire logic [7:0] c2t_data, // card to terminal byte
  input wire logic c2t_valid, // card byte offered
  input wire logic c2t_ready // terminal ready
);
  // card data bytes other than 60 with high nibble 6 or 9 would look like status here; keep them out
  logic t2c_x;
  logic c2t_x;
  logic sw_byte;
  logic half_reg;
  logic [7:0] sw1_reg;
  logic [7:0] xx_reg;
  logic [2:0] cnt_reg;
  assign t2c_x = t2c_valid && t2c_ready;
  assign c2t_x = c2t_valid && c2t_ready;
  assign sw_byte = (c2t_data[7:4] == 4'h6 || c2t_data[7:4] == 4'h9) && c2t_data != 8'h60;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_reg <= 1'b0;
      sw1_reg <= 8'h00;
      xx_reg <= 8'h00;
    end else if (c2t_x && half_reg) begin
      half_reg <= 1'b0;
      xx_reg <= c2t_data;
    end else if (c2t_x && sw_byte) begin
      half_reg <= 1'b1;
      sw1_reg <= c2t_data;
    end
  end

  // position within the header that must follow a 61 or 6c pair
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 3'h0;
    end else if (c2t_x && half_reg) begin
      cnt_reg <= (sw1_reg == 8'h61 || sw1_reg == 8'h6c) ? 3'h1 : 3'h0;
    end else if (t2c_x && cnt_reg != 3'h0) begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_t2c_hold: assert property (t2c_valid && !t2c_ready |=> t2c_valid && $stable(t2c_data))
    else $error("terminal byte changed before taken");
  a_c2t_hold: assert property (c2t_valid && !c2t_ready |=> c2t_valid && $stable(c2t_data))
    else $error("card byte changed before taken");
  a_t2c_gap: assert property (t2c_x |=> !t2c_valid)
    else $error("terminal valid not dropped after transfer");
  a_c2t_gap: assert property (c2t_x |=> !c2t_valid)
    else $error("card valid not dropped after transfer");
  a_gr_class: assert property (t2c_x && cnt_reg == 3'h1 && sw1_reg == 8'h61 |-> t2c_data == 8'h00)
    else $error("get response class byte wrong");
  a_gr_ins: assert property (t2c_x && cnt_reg == 3'h2 && sw1_reg == 8'h61 |-> t2c_data == 8'hc0)
    else $error("get response instruction wrong");
  a_gr_params: assert property (t2c_x && cnt_reg inside {3'h3, 3'h4} && sw1_reg == 8'h61
    |-> t2c_data == 8'h00)
    else $error("get response parameter byte wrong");
  a_gr_len: assert property (t2c_x && cnt_reg == 3'h5 && sw1_reg == 8'h61
    |-> xx_reg == 8'h00 || (t2c_data != 8'h00 && t2c_data <= xx_reg))
    else $error("get response length above offered");
  a_fix_len: assert property (t2c_x && cnt_reg == 3'h5 && sw1_reg == 8'h6c |-> t2c_data == xx_reg)
    else $error("resent header length not corrected");
  a_fix_prompt: assert property (c2t_x && half_reg && sw1_reg == 8'h6c |-> ##[1:20] t2c_x)
    else $error("header not resent promptly");
endmodule

// file: testbench/t0_apdu_transport_tb.sv
// self-checking bench: terminal and card ends joined over the byte link
`timescale 1ns/100ps
module t0_apdu_transport_tb import t0at_pkg::*; ;
  logic clk = 1'b0;
  logic reset, cmd_start, tx_valid, app_resp, app_ok, rd_valid, rd_bad, cfg_ok1, cfg_ok2;
  logic tx_ack, rsp_valid, rsp_done, rsp_err, busy, hdr_strobe, cdata_valid, rd_ack;
  logic [2:0] cmd_case, app_case;
  logic [7:0] cmd_lc, tx_data, rd_data, cur_lc, rsp_data, hdr_ins, hdr_p3, cdata;
  logic [8:0] app_len;
  logic [15:0] app_sw, cfg_sw1, cfg_sw2, rsp_sw;
  int ncd, nrsp, ngr, nhdr, rd_idx, tx_idx, fails, num_checks, test_no;

  always #25 clk = ~clk;

  t0at_link_if link_if();
  t0at_term t0at_term_inst (.clk(clk), .reset(reset), .cmd_start(cmd_start),
    .cmd_case(cmd_case), .cmd_cla(8'h80), .cmd_ins(8'hb2), .cmd_p1(8'h01), .cmd_p2(8'h02),
    .cmd_lc(cmd_lc), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ack(tx_ack),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_done(rsp_done), .rsp_sw(rsp_sw),
    .rsp_err(rsp_err), .busy(busy), .link(link_if));
  t0at_card t0at_card_inst (.clk(clk), .reset(reset), .hdr_strobe(hdr_strobe),
    .hdr_ins(hdr_ins), .hdr_p3(hdr_p3), .cdata(cdata), .cdata_valid(cdata_valid),
    .app_resp(app_resp), .app_case(app_case), .app_ok(app_ok), .app_sw(app_sw),
    .app_len(app_len), .rd_data(rd_data), .rd_valid(rd_valid), .rd_bad(rd_bad),
    .rd_ack(rd_ack), .link(link_if));
  t0at_props t0at_props_inst (.clk(clk), .reset(reset), .t2c_data(link_if.t2c_data),
    .t2c_valid(link_if.t2c_valid), .t2c_ready(link_if.t2c_ready),
    .c2t_data(link_if.c2t_data), .c2t_valid(link_if.c2t_valid),
    .c2t_ready(link_if.c2t_ready));

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task summarize;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // card application side and data sources; answers once per header other than get response and after the last byte
  always @(negedge clk) begin
    app_resp = (hdr_strobe === 1'b1 && hdr_ins !== T0AT_INS_GR) ||
               (cdata_valid === 1'b1 && ncd + 1 == cur_lc);
    app_ok = (cdata_valid === 1'b1) ? cfg_ok2 : cfg_ok1;
    app_sw = (cdata_valid === 1'b1) ? cfg_sw2 : cfg_sw1;
    if (hdr_strobe === 1'b1 && nhdr == 0) begin
      chk("p3", {8'h00, (cmd_case == T0AT_CASE2) ? T0AT_LE_ZERO : cmd_lc}, {8'h00, hdr_p3});
    end
    if (hdr_strobe === 1'b1) nhdr++;
    if (hdr_strobe === 1'b1 && hdr_ins === T0AT_INS_GR) ngr++;
    if (cdata_valid === 1'b1) begin
      chk("cdata", {8'h00, 8'ha0 + ncd[7:0]}, {8'h00, cdata});
      ncd++;
    end
    if (rsp_valid === 1'b1) begin
      chk("body", {10'h000, nrsp[5:0]}, {8'h00, rsp_data});
      nrsp++;
    end
    if (rd_ack === 1'b1) rd_idx++;
    if (tx_ack === 1'b1) tx_idx++;
    rd_data = {2'b00, rd_idx[5:0]};
    tx_data = 8'ha0 + tx_idx[7:0];
  end

  task run(input logic [2:0] c, input logic [7:0] lc, input logic ok1, input logic [15:0] sw1,
           input logic [8:0] len, input logic ok2, input logic [15:0] sw2, input logic bad,
           input logic [15:0] exp_sw, input int exp_n, input int exp_gr);
    int i;
    cmd_case = c;
    app_case = c;
    cmd_lc = lc;
    cur_lc = lc;
    cfg_ok1 = ok1;
    cfg_sw1 = sw1;
    cfg_ok2 = ok2;
    cfg_sw2 = sw2;
    app_len = len;
    rd_bad = bad;
    ncd = 0;
    nrsp = 0;
    ngr = 0;
    nhdr = 0;
    rd_idx = 0;
    tx_idx = 0;
    repeat (2) @(negedge clk);
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    i = 0;
    while (rsp_done !== 1'b1 && i < 4000) begin
      @(negedge clk);
      i++;
    end
    // a run that never finishes counts as a mismatch here
    chk("done", 16'h0001, {15'h0000, rsp_done});
    chk("idle", 16'h0000, {15'h0000, busy});
    chk("status", exp_sw, rsp_sw);
    chk("abandon", 16'h0000, {15'h0000, rsp_err});
    if (exp_n >= 0) chk("body count", exp_n[15:0], nrsp[15:0]);
    chk("get response", exp_gr[15:0], {15'h0000, ngr != 0});
    chk("data count", (c != T0AT_CASE2 && ok1) ? {8'h00, lc} : 16'h0000, ncd[15:0]);
    test_no++;
    $display("test %0d done", test_no);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    {cmd_start, app_resp, app_ok, rd_bad, cfg_ok1, cfg_ok2} = 6'h00;
    tx_valid = 1'b1;
    rd_valid = 1'b1;
    {cmd_case, app_case, cmd_lc, cur_lc, app_len} = 31'h0;
    {app_sw, cfg_sw1, cfg_sw2} = 48'h0;
    {tx_data, rd_data} = 16'h0000;
    {ncd, nrsp, ngr, nhdr, rd_idx, tx_idx, fails, num_checks, test_no} = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    run(T0AT_CASE2, 8'h00, 1'b1, 16'h0000, 9'h004, 1'b1, 16'h0000, 1'b0, T0AT_SW_OK, 4, 0);
    run(T0AT_CASE2, 8'h00, 1'b1, 16'h0000, 9'h100, 1'b1, 16'h0000, 1'b1, 16'h6281, 256, 0);
    run(T0AT_CASE2, 8'h00, 1'b0, 16'h6a82, 9'h004, 1'b1, 16'h0000, 1'b0, 16'h6a82, 0, 0);
    run(T0AT_CASE3, 8'h03, 1'b1, 16'h0000, 9'h001, 1'b1, 16'h0000, 1'b0, T0AT_SW_OK, 0, 0);
    run(T0AT_CASE3, 8'h03, 1'b0, 16'h6985, 9'h001, 1'b1, 16'h0000, 1'b0, 16'h6985, 0, 0);
    run(T0AT_CASE4, 8'h02, 1'b1, 16'h0000, 9'h005, 1'b1, 16'h0000, 1'b0, T0AT_SW_OK, 5, 1);
    run(T0AT_CASE4, 8'h01, 1'b1, 16'h0000, 9'h003, 1'b0, 16'h6283, 1'b0, 16'h6283, 0, 1);
    run(T0AT_CASE4, 8'h01, 1'b1, 16'h0000, 9'h003, 1'b0, 16'h9123, 1'b0, 16'h9123, 0, 1);
    run(T0AT_CASE4, 8'h01, 1'b1, 16'h0000, 9'h003, 1'b0, 16'h6a80, 1'b0, 16'h6a80, 0, 0);
    summarize();
  end
endmodule
